/* File: tb_top.sv */
`timescale 1ns/1ps

module tb_top
    import tdmst_pkg::*;
;
    typedef struct {logic [13:0] a; logic [15:0] w; logic [15:0] r;} tdmst_row_t;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cs_b = 1'b1;
    logic rd_b = 1'b1;
    logic wr_b = 1'b1;
    logic [13:0] addr = 14'h0000;
    logic [15:0] data_in = 16'h0000;
    logic [15:0] rdv;
    int in_dly = 0;
    int out_adv = 0;
    int fail_count = 0;
    int compares = 0;
    logic ck_in, fp_in_b, data_oe, dta_rdy_b;
    logic [15:0] sti, stio_out, stio_oe, data_out;
    tdmst_row_t rows [6] = '{'{ADDR_SICR, 16'hffff, 16'h01ff}, '{ADDR_SOCR + 14'h0005, 16'hffff,
        16'h01ff}, '{ADDR_CTRL, 16'hfffc, 16'h0010}, '{ADDR_CM + 14'h0105, 16'hffff, 16'h7fff},
        '{14'h0800, 16'h1234, 16'h0000}, '{ADDR_IMS, 16'hffff, 16'h0040}};
    // out channel, source channel, variable, frames of lag
    int cmt [6][4] = '{'{10, 2, 1, 0}, '{3, 5, 1, 1}, '{12, 6, 1, 1}, '{20, 13, 1, 1},
        '{4, 4, 0, 2}, '{1, 9, 0, 2}};

    tdmst_core i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .ck_in(ck_in), .fp_in_b(fp_in_b),
        .sti(sti), .stio_in(stio_out), .stio_out(stio_out), .stio_oe(stio_oe), .cs_b(cs_b),
        .rd_b(rd_b), .wr_b(wr_b), .addr(addr), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .dta_rdy_b(dta_rdy_b));
    tdmst_far_model i_far (.ref_clk(ref_clk), .stio_out(stio_out), .in_dly(in_dly),
        .out_adv(out_adv), .ck_in(ck_in), .fp_in_b(fp_in_b), .sti(sti));

    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one strobe per access; held until acknowledge is sampled low
    task automatic access(input logic wr, input logic [13:0] a, input logic [15:0] d);
        int n;
        @(negedge ref_clk);
        addr = a;
        data_in = d;
        cs_b = 1'b0;
        wr_b = !wr;
        rd_b = wr;
        n = 0;
        while (dta_rdy_b !== 1'b0 && n < 400)
        begin
            @(posedge ref_clk);
            n++;
        end
        rdv = data_out;
        @(negedge ref_clk);
        cs_b = 1'b1;
        rd_b = 1'b1;
        wr_b = 1'b1;
        while (dta_rdy_b !== 1'b1 && n < 400)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 400)
            check("host handshake", 16'h0001, 16'h0000);
    endtask : access

    task automatic report_and_stop;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (90000) @(posedge ref_clk);
        fail_count++;
        report_and_stop();
    end

    initial
    begin
        int tgt;
        logic [7:0] exp8;
        logic [7:0] got8;
        repeat (6) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (8) @(negedge ref_clk);
        foreach (rows[i])
        begin
            access(1'b1, rows[i].a, rows[i].w);
            access(1'b0, rows[i].a, 16'h0000);
            check("register", rdv, rows[i].r);
        end
        // ------------------------------------------------------------
        // reset in mid-run
        // ------------------------------------------------------------
        rst_b = 1'b0;
        repeat (6) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (8) @(negedge ref_clk);
        access(1'b0, ADDR_SICR, 16'h0000);
        check("input control", rdv, 16'h0020);
        access(1'b0, ADDR_SOCR + 14'h0005, 16'h0000);
        check("output control", rdv, 16'h0000);
        access(1'b0, ADDR_IMS, 16'h0000);
        check("mode", rdv, 16'h0000);
        // ------------------------------------------------------------
        // switching traffic
        // ------------------------------------------------------------
        access(1'b1, ADDR_CTRL, 16'h0010);
        access(1'b1, ADDR_SICR + 14'h0001, 16'h00e0);
        in_dly = 12;
        access(1'b1, ADDR_SOCR + 14'h0002, 16'h0110);
        out_adv = 6;
        access(1'b1, ADDR_CM + 14'h0201, 16'h0529);
        foreach (cmt[i])
            access(1'b1, ADDR_CM + 14'(cmt[i][0]),
                16'((cmt[i][2] << 14) | 512 | (cmt[i][1] << 1)));
        tgt = (i_far.aq / 1024 + 5) * 1024 + 960;
        wait (i_far.aq >= tgt);
        foreach (cmt[i])
        begin
            exp8 = i_far.pat(i_far.rxf[0][cmt[i][0]] - cmt[i][3], 1, cmt[i][1]);
            got8 = i_far.rx[0][cmt[i][0]];
            check("switched", {8'h00, got8}, {8'h00, exp8});
        end
        check("message byte", {8'h00, i_far.rx[2][1]}, 16'h00a5);
        report_and_stop();
    end
endmodule : tb_top

/* File: tdmst_asserts.sv */
`timescale 1ns/1ps

module tdmst_asserts
    import tdmst_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic rd_b,
    input wire logic [15:0] stio_oe,
    input wire logic data_oe,
    input wire logic dta_rdy_b
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------
    // host strobe sequences
    // ------------------------------------------------------------
    sequence s_idle_bus;
        cs_b [*8];
    endsequence

    sequence s_read_held;
        (!cs_b && !rd_b) [*8];
    endsequence

    AST_RESET_QUIET: assert property ($rose(rst_b) |-> !stio_oe && !data_oe && dta_rdy_b)
        else $error("outputs active at reset release");
    AST_DRIVE_AFTER: assert property (rst_b && $past(rst_b, 2) |-> stio_oe == 16'hffff)
        else $error("stream drivers off after reset");
    AST_ACK_CAUSE: assert property ($fell(dta_rdy_b) |-> !$past(cs_b, 3))
        else $error("acknowledge without chip select");
    AST_OE_ACK: assert property (data_oe |-> !dta_rdy_b)
        else $error("data driven without acknowledge");
    AST_OE_READ: assert property ($rose(data_oe) |-> !$past(rd_b, 3))
        else $error("data driven without read strobe");
    AST_IDLE_REL: assert property (s_idle_bus |-> dta_rdy_b && !data_oe)
        else $error("acknowledge stuck after release");
    AST_READ_ANS: assert property (s_read_held |-> ##[0:300] !dta_rdy_b)
        else $error("read not answered");
    AST_ACK_HOLD: assert property ((!dta_rdy_b && !cs_b) ##1 !cs_b |-> !dta_rdy_b)
        else $error("acknowledge dropped while selected");
endmodule : tdmst_asserts

bind tdmst_core tdmst_asserts i_chk (.ref_clk(ref_clk), .rst_b(rst_b), .cs_b(cs_b),
    .rd_b(rd_b), .stio_oe(stio_oe), .data_oe(data_oe), .dta_rdy_b(dta_rdy_b));

/* File: tdmst_core.sv */
`timescale 1ns/1ps

// What this block does
// - input sampling delayed 0..7 bits per stream
// - zero delay: first bit is bit 7
// - quarter-bit sample point, reset at 2/4
// - output advanced 0..7 bits per stream
// - zero advance: bit 7 first after boundary
// - fractional output advance 0..3/4 bit
// - bit 14 picks variable or constant delay
// - variable delay sends at earliest opportunity
// - variable delay frame choice from n-m
// - constant delay is two frames plus n-m
// - constant delay honoured despite global enable
// - whole word access, unused bits zero
// - flag clear: switch from stream/channel fields, idle byte if bit 13 set
// - flag set: message byte output
// - 32 to 256 channels per stream
// - bidirectional: inputs sampled from stio, stio_oe stays all ones
module tdmst_core
    import tdmst_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ck_in,
    input wire logic fp_in_b,
    input wire logic [15:0] sti,
    input wire logic [15:0] stio_in,
    output logic [15:0] stio_out,
    output logic [15:0] stio_oe,
    input wire logic cs_b,
    input wire logic rd_b,
    input wire logic wr_b,
    input wire logic [13:0] addr,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe,
    output logic dta_rdy_b
);

    typedef struct packed {
        tdmst_pins_t [SYNC_STAGES-1:0] sy;
        tdmst_pins_t lvl;
        logic tick;
        logic fp_prev;
        logic [13:0] qpos;
        logic [1:0] bank;
        logic [NSTR-1:0][7:0] in_sh;
        logic [NSTR-1:0][7:0] out_sh;
        logic [15:0] stio_out;
        logic [15:0] stio_oe;
        logic [15:0] ctrl;
        logic [15:0] internal_mode_register;
        logic [NSTR-1:0][15:0] sicr;
        logic [NSTR-1:0][15:0] socr;
        tdmst_host_t hs;
        tdmst_req_t req;
        logic [15:0] data_out;
        logic data_oe;
        logic dta_rdy_b;
    } tdmst_st_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic tdmst_st_t rst_state();
        tdmst_st_t r;
        r = '0;
        r.sicr = {NSTR{SICR_RST}};
        r.socr = {NSTR{SOCR_RST}};
        r.ctrl = CTRL_RST;
        r.internal_mode_register = IMS_RST;
        r.qpos = QPOS_RST;
        r.bank = BANK_RST;
        r.hs = TDMST_H_IDLE;
        r.dta_rdy_b = 1'b1;
        r.lvl.cs_b = 1'b1;
        r.lvl.rd_b = 1'b1;
        r.lvl.wr_b = 1'b1;
        r.lvl.fp_b = 1'b1;
        // stages start at idle levels, or release looks like a strobe
        r.sy = {SYNC_STAGES{r.lvl}};
        r.fp_prev = 1'b1;
        return r;
    endfunction : rst_state

    localparam tdmst_st_t ST_RST = rst_state();

    // a pin level moves only where the last two stages agree
    function automatic tdmst_pins_t filt(input tdmst_pins_t s2, input tdmst_pins_t s3,
                                         input tdmst_pins_t l);
        logic [$bits(tdmst_pins_t)-1:0] agree;
        agree = ~(s2 ^ s3);
        return (s3 & agree) | (l & ~agree);
    endfunction : filt

    function automatic logic [1:0] bank_prev(input logic [1:0] b);
        return (b == '0) ? BANK_LAST : b - 2'h1;
    endfunction : bank_prev

    function automatic logic [1:0] bank_next(input logic [1:0] b);
        return (b == BANK_LAST) ? '0 : b + 2'h1;
    endfunction : bank_next

    function automatic tdmst_dec_t decode(input logic [13:0] a);
        tdmst_dec_t r;
        r.sel = TDMST_SEL_NONE;
        r.idx = {2'b00, a[9:0]};
        if (a == ADDR_CTRL)
        begin
            r.sel = TDMST_SEL_CTRL;
        end
        else if (a == ADDR_IMS)
        begin
            r.sel = TDMST_SEL_IMS;
        end
        else if (a[13:4] == ADDR_SICR[13:4])
        begin
            r.sel = TDMST_SEL_SICR;
        end
        else if (a[13:4] == ADDR_SOCR[13:4])
        begin
            r.sel = TDMST_SEL_SOCR;
        end
        else if (a[13:12] == ADDR_CM[13:12])
        begin
            r.sel = TDMST_SEL_CM;
            r.idx = a[11:0];
        end
        return r;
    endfunction : decode

    tdmst_st_t q;
    tdmst_st_t d;
    tdmst_pins_t pins;
    logic [7:0] dmem [0:16383];
    logic [15:0] cmem [0:4095];
    logic [NSTR-1:0] dm_we;
    logic [NSTR-1:0][13:0] dm_waddr;
    logic [NSTR-1:0][7:0] dm_wdata;
    logic cm_we;
    logic [11:0] cm_waddr;
    logic [15:0] cm_wdata;
    logic f_in_valid;
    logic f_in_ready;
    logic f_out_valid;
    logic f_out_ready;
    tdmst_req_t f_out;

    // ------------------------------------------------------------
    // host write buffer
    // ------------------------------------------------------------
    // memory ports are busy on quarter ticks; draining stalls on the registered tick, one cycle later
    assign f_in_valid = (q.hs == TDMST_H_WRQ);
    assign f_out_ready = !q.tick;

    tdmst_fifo #(
        .W($bits(tdmst_req_t)),
        .D(FIFO_DEPTH)
    ) u_wbuf (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(q.req),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out)
    );

    always_comb
    begin
        pins.cs_b = cs_b;
        pins.rd_b = rd_b;
        pins.wr_b = wr_b;
        pins.ck = ck_in;
        pins.fp_b = fp_in_b;
        pins.addr = addr;
        pins.data = data_in;
        pins.sti = sti;
        pins.stio = stio_in;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic edge_hit;
        logic fstart;
        logic [13:0] fq;
        logic [13:0] qn;
        logic [1:0] bn;
        logic [13:0] dly;
        logic [13:0] rel;
        logic [13:0] opos;
        logic [1:0] ibank;
        logic [1:0] obank;
        logic [1:0] rbank;
        logic [7:0] shv;
        logic [7:0] byt;
        logic [7:0] m;
        logic [7:0] n;
        logic [3:0] ss;
        logic [15:0] cw;
        logic [15:0] rdv;
        logic inb;
        logic same;
        tdmst_dec_t dec;
        tdmst_dec_t wdec;
        edge_hit = 1'b0;
        fstart = 1'b0;
        fq = '0;
        qn = '0;
        bn = '0;
        dly = '0;
        rel = '0;
        opos = '0;
        ibank = '0;
        obank = '0;
        rbank = '0;
        shv = '0;
        byt = '0;
        m = '0;
        n = '0;
        ss = '0;
        cw = '0;
        rdv = '0;
        inb = 1'b0;
        same = 1'b0;
        dec = decode(q.req.addr);
        wdec = decode(f_out.addr);
        d = q;
        dm_we = '0;
        dm_waddr = '0;
        dm_wdata = '0;
        cm_we = 1'b0;
        cm_waddr = wdec.idx;
        cm_wdata = f_out.data;

        d.sy = {q.sy[SYNC_STAGES-2:0], pins};
        d.lvl = filt(q.sy[1], q.sy[2], q.lvl);
        // each settled clock edge is one quarter-bit instant
        edge_hit = (d.lvl.ck != q.lvl.ck);
        // pulse level is judged per clock edge, not per system cycle
        fstart = edge_hit && !d.lvl.fp_b && q.fp_prev;
        d.fp_prev = edge_hit ? d.lvl.fp_b : q.fp_prev;
        d.tick = edge_hit;

        fq = FRAME_Q_MIN << q.ctrl[CTRL_RATE_LSB +: 2];
        qn = q.qpos;
        bn = q.bank;
        if (fstart)
        begin
            qn = QPOS_RST;
            bn = bank_next(q.bank);
        end
        else if (edge_hit)
        begin
            qn = (q.qpos == fq - 14'h1) ? QPOS_RST : q.qpos + 14'h1;
            bn = (q.qpos == fq - 14'h1) ? bank_next(q.bank) : q.bank;
        end
        d.qpos = qn;
        d.bank = bn;
        d.stio_oe = '1;

        for (int s = 0; s < NSTR; s++)
        begin
            // ---------------- input side ----------------
            dly = {9'h000, q.sicr[s][SICR_BD_LSB +: 3], 2'b00};
            ibank = (qn < dly) ? bank_prev(bn) : bn;
            rel = (qn < dly) ? qn + fq - dly : qn - dly;
            // bidirectional mode samples the stio pins in place of sti
            inb = q.internal_mode_register[IMS_BIDIR_BIT] ? q.lvl.stio[s] : q.lvl.sti[s];
            if (edge_hit && rel[1:0] == q.sicr[s][SICR_SMP_LSB +: 2])
            begin
                shv = {q.in_sh[s][6:0], inb};
                d.in_sh[s] = shv;
                if (rel[4:2] == LAST_BIT)
                begin
                    dm_we[s] = 1'b1;
                    dm_waddr[s] = {ibank, 4'(s), rel[12:5]};
                    dm_wdata[s] = shv;
                end
            end

            // ---------------- output side ----------------
            opos = qn + {9'h000, q.socr[s][SOCR_AD_LSB +: 3], 2'b00}
                + {12'h000, q.socr[s][SOCR_FA_LSB +: 2]};
            obank = (opos >= fq) ? bank_next(bn) : bn;
            opos = (opos >= fq) ? opos - fq : opos;
            if (edge_hit && opos[1:0] == BIT_EDGE)
            begin
                if (opos[4:2] == FIRST_BIT)
                begin
                    n = opos[12:5];
                    cw = cmem[{4'(s), n}];
                    m = cw[CM_SCA_LSB +: 8];
                    ss = cw[CM_SSA_LSB +: 4];
                    // earliest slot: same frame only if the source is already stored
                    same = (n > m) && ((n - m > THRU_MIN)
                        || ((n - m == THRU_MIN) && (4'(s) >= ss)));
                    if (cw[CM_VAR_BIT])
                    begin
                        rbank = same ? obank : bank_prev(obank);
                    end
                    else
                    begin
                        rbank = bank_prev(bank_prev(obank));
                    end
                    byt = dmem[{rbank, ss, m}];
                    if (cw[CM_FLAG_BIT])
                    begin
                        byt = cw[CM_MSG_LSB +: 8];
                    end
                    else if (cw[CM_SSA_LSB + 4])
                    begin
                        byt = IDLE_BYTE;
                    end
                    d.stio_out[s] = byt[7];
                    d.out_sh[s] = {byt[6:0], 1'b0};
                end
                else
                begin
                    d.stio_out[s] = q.out_sh[s][7];
                    d.out_sh[s] = {q.out_sh[s][6:0], 1'b0};
                end
            end
        end

        // ---------------- buffered write drain ----------------
        if (f_out_valid && f_out_ready)
        begin
            case (wdec.sel)
                TDMST_SEL_CTRL: d.ctrl = f_out.data & CTRL_MASK;
                TDMST_SEL_IMS: d.internal_mode_register = f_out.data & IMS_MASK;
                TDMST_SEL_SICR: d.sicr[wdec.idx[3:0]] = f_out.data & SCR_MASK;
                TDMST_SEL_SOCR: d.socr[wdec.idx[3:0]] = f_out.data & SCR_MASK;
                TDMST_SEL_CM: cm_we = 1'b1;
                default: cm_we = 1'b0;
            endcase
        end

        // ---------------- read data ----------------
        case (dec.sel)
            TDMST_SEL_CTRL: rdv = q.ctrl;
            TDMST_SEL_IMS: rdv = q.internal_mode_register;
            TDMST_SEL_SICR: rdv = q.sicr[dec.idx[3:0]];
            TDMST_SEL_SOCR: rdv = q.socr[dec.idx[3:0]];
            TDMST_SEL_CM: rdv = cmem[dec.idx] & CM_MASK;
            default: rdv = '0;
        endcase

        // ---------------- host port sequencer ----------------
        case (q.hs)
            TDMST_H_IDLE:
            begin
                d.req.addr = q.lvl.addr;
                d.req.data = q.lvl.data;
                if (!q.lvl.cs_b && !q.lvl.wr_b)
                begin
                    d.hs = TDMST_H_WRQ;
                end
                else if (!q.lvl.cs_b && !q.lvl.rd_b)
                begin
                    d.hs = TDMST_H_RDW;
                end
            end
            TDMST_H_WRQ:
            begin
                // a full buffer holds the ready line back
                if (f_in_ready)
                begin
                    d.hs = TDMST_H_HOLD;
                    d.dta_rdy_b = 1'b0;
                end
            end
            TDMST_H_RDW:
            begin
                // reads wait for queued writes so they never see stale data
                if (!f_out_valid)
                begin
                    d.data_out = rdv;
                    d.data_oe = 1'b1;
                    d.dta_rdy_b = 1'b0;
                    d.hs = TDMST_H_HOLD;
                end
            end
            TDMST_H_HOLD:
            begin
                if (q.lvl.cs_b || (q.lvl.rd_b && q.lvl.wr_b))
                begin
                    d.dta_rdy_b = 1'b1;
                    d.data_oe = 1'b0;
                    d.hs = TDMST_H_IDLE;
                end
            end
            default: d.hs = TDMST_H_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers and memories
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q <= ST_RST;
        end
        else
        begin
            q <= d;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        for (int s = 0; s < NSTR; s++)
        begin
            if (dm_we[s])
            begin
                dmem[dm_waddr[s]] <= dm_wdata[s];
            end
        end
        if (cm_we)
        begin
            cmem[cm_waddr] <= cm_wdata;
        end
    end

    assign stio_out = q.stio_out;
    assign stio_oe = q.stio_oe;
    assign data_out = q.data_out;
    assign data_oe = q.data_oe;
    assign dta_rdy_b = q.dta_rdy_b;

endmodule : tdmst_core

/* File: tdmst_far_model.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// framed serial devices on the far side
// ------------------------------------------------------------
module tdmst_far_model
(
    input wire logic ref_clk,
    input wire logic [15:0] stio_out,
    input int in_dly,
    input int out_adv,
    output logic ck_in,
    output logic fp_in_b,
    output logic [15:0] sti
);
    int aq = 0;
    logic [7:0] rx [16][32];
    int rxf [16][32];

    // byte of stream s channel c in frame f; changes every frame
    function automatic logic [7:0] pat(input int f, input int s, input int c);
        return 8'(f * 40 + s * 3 + c);
    endfunction : pat

    initial
    begin
        int e;
        int g;
        logic [7:0] b8;
        ck_in = 1'b0;
        fp_in_b = 1'b1;
        sti = 16'h0000;
        forever
        begin
            repeat (4) @(negedge ref_clk);
            e = aq + 1;
            // pulse straddles the boundary edge so it is seen settled
            fp_in_b = (e % 1024) != 0;
            g = (e - in_dly) / 4;
            if (e >= in_dly && (e - in_dly) % 4 == 0)
            begin
                for (int s = 0; s < 16; s++)
                begin
                    b8 = pat(g / 256, s, (g % 256) / 8);
                    sti[s] = b8[7 - g % 8];
                end
            end
            repeat (4) @(negedge ref_clk);
            ck_in = ~ck_in;
            aq = aq + 1;
            // only stream 2 is advanced; sample mid-bit
            for (int s = 0; s < 16; s++)
            begin
                g = aq + ((s == 2) ? out_adv : 0);
                if (g % 4 == 2)
                begin
                    rx[s][(g % 1024) / 32][7 - (g % 32) / 4] = stio_out[s];
                    rxf[s][(g % 1024) / 32] = g / 1024;
                end
            end
        end
    end
endmodule : tdmst_far_model

/* File: tdmst_fifo.sv */
`timescale 1ns/1ps

module tdmst_fifo
    import tdmst_pkg::*;
#(
    parameter int W = 30,
    parameter int D = 8
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } tdmst_fst_t;

    tdmst_fst_t q;
    tdmst_fst_t d;
    logic [W-1:0] mem [0:D-1];
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // flags and pointers
    // ------------------------------------------------------------
    assign in_ready = (q.cnt != (AW+1)'(D));
    assign out_valid = (q.cnt != '0);
    assign out_data = mem[q.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        d = q;
        if (push)
        begin
            d.wp = (q.wp == AW'(D-1)) ? '0 : q.wp + AW'(1);
        end
        if (pop)
        begin
            d.rp = (q.rp == AW'(D-1)) ? '0 : q.rp + AW'(1);
        end
        if (push && !pop)
        begin
            d.cnt = q.cnt + (AW+1)'(1);
        end
        else if (pop && !push)
        begin
            d.cnt = q.cnt - (AW+1)'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // storage is not reset; only the pointers matter
    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem[q.wp] <= in_data;
        end
    end

endmodule : tdmst_fifo

/* File: tdmst_pkg.sv */
package tdmst_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NSTR = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int SYNC_STAGES = 3;

    // ------------------------------------------------------------
    // host port map
    // ------------------------------------------------------------
    localparam logic [13:0] ADDR_CTRL = 14'h0000;
    localparam logic [13:0] ADDR_IMS = 14'h0001;
    localparam logic [13:0] ADDR_SICR = 14'h0010;
    localparam logic [13:0] ADDR_SOCR = 14'h0020;
    localparam logic [13:0] ADDR_CM = 14'h1000;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_RATE_LSB = 0;
    localparam int CTRL_VARIABLE_DELAY_GLOBAL_ENABLE_BIT = 4;
    localparam int IMS_BIDIR_BIT = 6;
    localparam int SICR_BD_LSB = 6;
    localparam int SICR_SMP_LSB = 4;
    localparam int SOCR_AD_LSB = 4;
    localparam int SOCR_FA_LSB = 7;
    localparam int CM_FLAG_BIT = 0;
    localparam int CM_SCA_LSB = 1;
    localparam int CM_SSA_LSB = 9;
    localparam int CM_MSG_LSB = 3;
    localparam int CM_VAR_BIT = 14;

    // ------------------------------------------------------------
    // read masks and values after reset
    // ------------------------------------------------------------
    localparam logic [15:0] CTRL_MASK = 16'h0013;
    localparam logic [15:0] IMS_MASK = 16'h0040;
    localparam logic [15:0] SCR_MASK = 16'h01ff;
    localparam logic [15:0] CM_MASK = 16'h7fff;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] IMS_RST = 16'h0000;
    localparam logic [15:0] SICR_RST = 16'h0020;
    localparam logic [15:0] SOCR_RST = 16'h0000;
    localparam logic [13:0] QPOS_RST = 14'h0000;
    localparam logic [1:0] BANK_RST = 2'h0;

    // ------------------------------------------------------------
    // frame timing counts
    // ------------------------------------------------------------
    // quarter-bits per frame at the lowest rate: 32 ch x 8 bit x 4
    localparam logic [13:0] FRAME_Q_MIN = 14'h0400;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] FIRST_BIT = 3'h0;
    localparam logic [1:0] BIT_EDGE = 2'h0;
    localparam logic [7:0] THRU_MIN = 8'h07;
    localparam logic [7:0] IDLE_BYTE = 8'hff;
    localparam logic [1:0] BANK_LAST = 2'h2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [13:0] addr;
        logic [15:0] data;
    } tdmst_req_t;

    typedef struct packed {
        logic cs_b;
        logic rd_b;
        logic wr_b;
        logic ck;
        logic fp_b;
        logic [13:0] addr;
        logic [15:0] data;
        logic [15:0] sti;
        logic [15:0] stio;
    } tdmst_pins_t;

    typedef enum logic [2:0] {
        TDMST_SEL_NONE,
        TDMST_SEL_CTRL,
        TDMST_SEL_IMS,
        TDMST_SEL_SICR,
        TDMST_SEL_SOCR,
        TDMST_SEL_CM
    } tdmst_sel_t;

    typedef struct packed {
        tdmst_sel_t sel;
        logic [11:0] idx;
    } tdmst_dec_t;

    typedef enum logic [1:0] {
        TDMST_H_IDLE,
        TDMST_H_WRQ,
        TDMST_H_RDW,
        TDMST_H_HOLD
    } tdmst_host_t;

endpackage : tdmst_pkg
